/* File: pkg/cfg_lanes_pkg.sv */
// =====================================================================
// Shared constants, modes and lane helpers
package cfg_lanes_pkg;

  // =====================================================================
  // Widths and buffering
  localparam int LANES      = 8;
  localparam int FIFO_W     = 9;   // Byte plus end-of-image flag
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W      = 16;

  // =====================================================================
  // Pin levels
  localparam logic [7:0] DATA_ALL_HIGH = 8'hFF;
  localparam logic [7:0] DATA_ALL_LOW  = 8'h00;

  // =====================================================================
  // Timing, all derived from the 40 MHz system clock
  localparam int CLOCK_MHZ       = 40;
  localparam int SHIFT_HALF_NS   = 50;    // Least half period of shift_clock
  localparam int ERR_PULSE_NS    = 1000;  // Least low time on the error line
  localparam int TRIG_PULSE_NS   = 2000;  // Least low time on the reconfig line
  localparam int SHIFT_HALF_CYC  = (SHIFT_HALF_NS * CLOCK_MHZ + 999) / 1000;
  localparam int ERR_PULSE_CYC   = (ERR_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int TRIG_PULSE_CYC  = (TRIG_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0] HALF_LAST = 8'(SHIFT_HALF_CYC - 1);
  localparam logic [7:0] ERR_LOAD  = 8'(ERR_PULSE_CYC);
  localparam logic [7:0] TRIG_LOAD = 8'(TRIG_PULSE_CYC);

  // =====================================================================
  // Lane modes: serial with 1, 2, 4 or 8 lanes, or byte parallel
  typedef enum logic [2:0] {
    MODE_PS1,
    MODE_PS2,
    MODE_PS4,
    MODE_PS8,
    MODE_BYTE
  } lane_mode_t;

  // Number of live lanes for a mode
  function automatic logic [3:0] lane_count(input lane_mode_t m);
    unique case (m)
      MODE_PS1: return 4'h1;
      MODE_PS2: return 4'h2;
      MODE_PS4: return 4'h4;
      default:  return 4'h8;
    endcase
  endfunction

  // Live-lane mask, idle lanes forced low
  function automatic logic [7:0] lane_mask(input lane_mode_t m);
    return 8'((9'h001 << lane_count(m)) - 9'h001);
  endfunction

  // Shift_clock cycles needed to send one byte
  function automatic logic [3:0] slices_per_byte(input lane_mode_t m);
    return m == MODE_BYTE ? 4'h1 : 4'(4'h8 / lane_count(m));
  endfunction

  // Bits of one time slice, lane i carries bit idx*n+i
  function automatic logic [7:0] lane_slice(input logic [7:0] b, input logic [2:0] idx, input lane_mode_t m);
    logic [7:0] sh;
    sh = b >> ({1'b0, idx} * lane_count(m));
    return sh & lane_mask(m);
  endfunction

endpackage

/* File: pkg/cfg_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Link between the configuration source and one configured chain
interface cfg_link_if;
  logic       shift_clock;
  logic [7:0] data;
  logic       src_err_out;
  logic       src_err_oe;
  logic       snk_err_out;
  logic       snk_err_oe;
  logic       snk_done_out;
  logic       snk_done_oe;
  logic       trig_out;
  logic       trig_oe;
  logic       err_pullup_en;
  logic       done_pullup_en;
  logic       shared_error_line;
  logic       configuration_complete;
  logic       reconfig_request_in;

  // Open-drain lines: low when any enabled driver drives low
  assign shared_error_line      = ~((src_err_oe & ~src_err_out) | (snk_err_oe & ~snk_err_out));
  assign configuration_complete = ~(snk_done_oe & ~snk_done_out);
  assign reconfig_request_in    = ~(trig_oe & ~trig_out);

  modport source (
    output shift_clock, data, src_err_out, src_err_oe, trig_out, trig_oe,
    output err_pullup_en, done_pullup_en,
    input  shared_error_line, configuration_complete
  );

  modport sink (
    input  shift_clock, data, shared_error_line, configuration_complete, reconfig_request_in,
    output snk_err_out, snk_err_oe, snk_done_out, snk_done_oe
  );
endinterface
`default_nettype wire

/* File: design/lane_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Small synchronous FIFO with valid/ready on both sides
module lane_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [PTR_W:0]              cnt;
  } fifo_state_t;

  fifo_state_t s_ff, nxt_s;
  logic        push, pop;

  // Honest full and empty flags
  assign in_ready  = s_ff.cnt != (PTR_W+1)'(DEPTH);
  assign out_valid = s_ff.cnt != '0;
  assign out_data  = s_ff.mem[s_ff.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data;
      nxt_s.wr = (s_ff.wr == PTR_W'(DEPTH - 1)) ? '0 : s_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd = (s_ff.rd == PTR_W'(DEPTH - 1)) ? '0 : s_ff.rd + 1'b1;
    end
    if (push && !pop) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule
`default_nettype wire

/* File: design/config_source.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Configuration source: buffers image bytes and drives the lanes
// Summary of operation
// - Byte mode sends whole byte each shift_clock.
// - Receiver takes one slice of the live lanes every shift_clock.
// - Single lane: bit on lane 0, others low.
// - Serial modes drive 1, 2, 4, 8 lanes.
// - Lanes above mode width held low while shifting.
// - Smallest covering mode; lowest lanes used.
// - Finished chain member enables the next one.
// - Members enter user mode together when complete.
// - Any error stops and restarts whole chain.
// - Source is sole feeder, no cascading.
// - Line pull-ups on by default, disable option.
// - Data changes away from rising shift_clock.
// - No data ready: shift_clock held stopped.
// - After completion: clock low, data high.
module config_source
  import cfg_lanes_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Image byte stream
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [7:0]        in_data,
  input  wire logic              in_last,
  // Control
  input  wire lane_mode_t        lane_mode,
  input  wire logic              pullup_disable,
  input  wire logic              fault_in,
  input  wire logic              reconfig_req,
  // Status
  output logic                   busy,
  output logic                   cfg_done,
  output logic                   error_active,
  output logic                   restart_pulse,
  // Link
  cfg_link_if.source             link
);

  // =====================================================================
  // State
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DONE,
    ST_ERROR
  } src_state_t;

  typedef struct packed {
    src_state_t  st;
    lane_mode_t  mode;
    logic [1:0]  err_sync;
    logic [1:0]  done_sync;
    logic        sclk;
    logic [7:0]  phase;
    logic [7:0]  shreg;
    logic        byte_last;
    logic [2:0]  slice_idx;
    logic [3:0]  slices_left;
    logic        loaded;
    logic [7:0]  data;
    logic [7:0]  err_cnt;
    logic [7:0]  trig_cnt;
    logic        restart;
    logic        pu_en;
    logic        pu_latched;
  } src_t;

  src_t             s_ff, nxt_s;
  logic             fifo_pop;
  logic             fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic             line_err;

  // =====================================================================
  // Image buffer; its ready is the fill-side back-pressure
  lane_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_last, in_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign line_err = ~s_ff.err_sync[1];

  // =====================================================================
  // Next-state logic
  always_comb begin
    nxt_s         = s_ff;
    fifo_pop      = 1'b0;
    nxt_s.restart = 1'b0;

    // Two-stage synchronisers on the shared lines
    nxt_s.err_sync  = {s_ff.err_sync[0], link.shared_error_line};
    nxt_s.done_sync = {s_ff.done_sync[0], link.configuration_complete};

    // Pull-up option caught once after reset, enabled unless disabled
    if (!s_ff.pu_latched) begin
      nxt_s.pu_en      = ~pullup_disable;
      nxt_s.pu_latched = 1'b1;
    end

    // Own error pulls the shared line low for the whole chain
    if (fault_in && s_ff.err_cnt == '0) begin
      nxt_s.err_cnt = ERR_LOAD;
    end else if (s_ff.err_cnt != '0) begin
      nxt_s.err_cnt = s_ff.err_cnt - 1'b1;
    end

    // Reconfiguration request pulse
    if (reconfig_req && s_ff.trig_cnt == '0) begin
      nxt_s.trig_cnt = TRIG_LOAD;
    end else if (s_ff.trig_cnt != '0) begin
      nxt_s.trig_cnt = s_ff.trig_cnt - 1'b1;
    end

    unique case (s_ff.st)
      ST_IDLE: begin
        nxt_s.sclk = 1'b0;
        nxt_s.data = DATA_ALL_LOW;
        // Start only while the chain is ready and not yet complete
        if (!line_err && !s_ff.done_sync[1]) begin
          nxt_s.st          = ST_RUN;
          nxt_s.mode        = lane_mode;
          nxt_s.loaded      = 1'b0;
          nxt_s.slices_left = '0;
          nxt_s.phase       = '0;
        end
      end

      ST_RUN: begin
        if (line_err) begin
          nxt_s.st   = ST_ERROR;
          nxt_s.sclk = 1'b0;
        end else if (!s_ff.sclk) begin
          if (!s_ff.loaded) begin
            // Clock stays low until a slice is ready
            nxt_s.phase = '0;
            if (s_ff.slices_left != '0) begin
              nxt_s.data   = lane_slice(s_ff.shreg, s_ff.slice_idx, s_ff.mode);
              nxt_s.loaded = 1'b1;
            end else if (fifo_valid) begin
              fifo_pop          = 1'b1;
              nxt_s.shreg       = fifo_data[7:0];
              nxt_s.byte_last   = fifo_data[8];
              nxt_s.slice_idx   = '0;
              nxt_s.slices_left = slices_per_byte(s_ff.mode);
              // Whole byte in byte mode, masked slice in serial modes
              nxt_s.data   = lane_slice(fifo_data[7:0], 3'h0, s_ff.mode);
              nxt_s.loaded = 1'b1;
            end
          end else if (s_ff.phase == HALF_LAST) begin
            // Data has stood a full half period before the rise
            nxt_s.sclk        = 1'b1;
            nxt_s.phase       = '0;
            nxt_s.loaded      = 1'b0;
            nxt_s.slice_idx   = s_ff.slice_idx + 1'b1;
            nxt_s.slices_left = s_ff.slices_left - 1'b1;
          end else begin
            nxt_s.phase = s_ff.phase + 1'b1;
          end
        end else if (s_ff.phase == HALF_LAST) begin
          nxt_s.sclk  = 1'b0;
          nxt_s.phase = '0;
          if (s_ff.slices_left == '0 && s_ff.byte_last) begin
            nxt_s.st   = ST_DONE;
            nxt_s.data = DATA_ALL_HIGH;
          end
        end else begin
          nxt_s.phase = s_ff.phase + 1'b1;
        end
      end

      ST_DONE: begin
        nxt_s.sclk = 1'b0;
        nxt_s.data = DATA_ALL_HIGH;
        if (line_err) begin
          nxt_s.st = ST_ERROR;
        end
      end

      ST_ERROR: begin
        // Stop the clock, drop stale bytes, wait for the line to rise
        nxt_s.sclk = 1'b0;
        nxt_s.data = DATA_ALL_LOW;
        fifo_pop   = fifo_valid;
        if (!line_err && s_ff.err_cnt == '0) begin
          nxt_s.st      = ST_IDLE;
          nxt_s.restart = 1'b1;
        end
      end
    endcase
  end

  // =====================================================================
  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff          <= '0;
      s_ff.st       <= ST_IDLE;
      s_ff.mode     <= MODE_PS1;
      s_ff.err_sync <= 2'h0;
      s_ff.pu_en    <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // =====================================================================
  // Link drive; this end alone sources the shift clock and data
  assign link.shift_clock    = s_ff.sclk;
  assign link.data           = s_ff.data;
  assign link.src_err_out    = 1'b0;
  assign link.src_err_oe     = s_ff.err_cnt != '0;
  assign link.trig_out       = 1'b0;
  assign link.trig_oe        = s_ff.trig_cnt != '0;
  assign link.err_pullup_en  = s_ff.pu_en;
  assign link.done_pullup_en = s_ff.pu_en;

  // =====================================================================
  // Status
  assign busy          = s_ff.st == ST_RUN;
  assign cfg_done      = (s_ff.st == ST_DONE) && s_ff.done_sync[1];
  assign error_active  = s_ff.st == ST_ERROR;
  assign restart_pulse = s_ff.restart;
endmodule
`default_nettype wire

/* File: design/config_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Configured chain member: captures lanes on shift_clock rising edges
module config_sink
  import cfg_lanes_pkg::*;
#(
  parameter logic [CNT_W-1:0] SAMPLE_COUNT = 16'h0010
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Control
  input  wire lane_mode_t  lane_mode,
  input  wire logic        chip_select_in_n,
  input  wire logic        crc_error,
  // Captured samples and chain status
  output logic [7:0]       sample_data,
  output logic             sample_valid,
  output logic             chain_enable_out_n,
  output logic             user_mode,
  // Link
  cfg_link_if.sink         link
);

  typedef struct packed {
    logic [1:0]       sclk_sync;
    logic             sclk_prev;
    logic [1:0]       sel_sync;
    logic [1:0]       err_sync;
    logic [1:0]       done_sync;
    logic [1:0]       rcfg_sync;
    logic [CNT_W-1:0] cnt;
    logic             done;
    logic [7:0]       err_cnt;
    logic [7:0]       sample;
    logic             valid;
    logic             ceo_n;
    logic             user;
  } snk_t;

  snk_t       s_ff, nxt_s;
  logic [7:0] cap_ff;
  logic       rise;

  // =====================================================================
  // Link domain: lanes caught on the rising edge, stable one period
  always_ff @(posedge link.shift_clock) begin
    cap_ff <= link.data;
  end

  // Edge seen through the synchronised clock level
  assign rise = s_ff.sclk_sync[1] & ~s_ff.sclk_prev;

  // =====================================================================
  // Next-state logic
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.valid     = 1'b0;
    nxt_s.sclk_sync = {s_ff.sclk_sync[0], link.shift_clock};
    nxt_s.sclk_prev = s_ff.sclk_sync[1];
    nxt_s.sel_sync  = {s_ff.sel_sync[0], chip_select_in_n};
    nxt_s.err_sync  = {s_ff.err_sync[0], link.shared_error_line};
    nxt_s.done_sync = {s_ff.done_sync[0], link.configuration_complete};
    nxt_s.rcfg_sync = {s_ff.rcfg_sync[0], link.reconfig_request_in};

    if (s_ff.err_cnt != '0) begin
      nxt_s.err_cnt = s_ff.err_cnt - 1'b1;
    end

    if (crc_error || !s_ff.rcfg_sync[1]) begin
      // Own error or reconfig request pulls the shared line low
      nxt_s.err_cnt = ERR_LOAD;
      nxt_s.cnt     = '0;
      nxt_s.done    = 1'b0;
      nxt_s.ceo_n   = 1'b1;
      nxt_s.user    = 1'b0;
    end else if (!s_ff.err_sync[1]) begin
      // Error from any member restarts this one too
      nxt_s.cnt   = '0;
      nxt_s.done  = 1'b0;
      nxt_s.ceo_n = 1'b1;
      nxt_s.user  = 1'b0;
    end else if (rise && !s_ff.sel_sync[1] && !s_ff.done) begin
      // One sample per shift_clock on the live lanes
      nxt_s.sample = cap_ff & lane_mask(lane_mode);
      nxt_s.valid  = 1'b1;
      nxt_s.cnt    = s_ff.cnt + 1'b1;
      if (s_ff.cnt == SAMPLE_COUNT - 1'b1) begin
        nxt_s.done  = 1'b1;
        nxt_s.ceo_n = 1'b0;
      end
    end

    // User mode only once the joint completion line is high
    if (s_ff.done && s_ff.done_sync[1] && s_ff.err_sync[1]) begin
      nxt_s.user = 1'b1;
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff           <= '0;
      s_ff.sel_sync  <= 2'h3;
      s_ff.err_sync  <= 2'h3;
      s_ff.rcfg_sync <= 2'h3;
      s_ff.ceo_n     <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // =====================================================================
  // Outputs; completion held low until this member is done
  assign link.snk_err_out   = 1'b0;
  assign link.snk_err_oe    = s_ff.err_cnt != '0;
  assign link.snk_done_out  = 1'b0;
  assign link.snk_done_oe   = ~s_ff.done;
  assign sample_data        = s_ff.sample;
  assign sample_valid       = s_ff.valid;
  assign chain_enable_out_n = s_ff.ceo_n;
  assign user_mode          = s_ff.user;
endmodule
`default_nettype wire

/* File: verif/config_data_output_lanes_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Link watcher: clock shape, lane use, error and end states
module config_data_output_lanes_monitor
  import cfg_lanes_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Mode of the source
  input  wire lane_mode_t lane_mode,
  // Link lines
  input  wire logic       shift_clock,
  input  wire logic [7:0] data,
  input  wire logic       src_err_oe,
  input  wire logic       trig_oe,
  input  wire logic       err_pullup_en,
  input  wire logic       done_pullup_en,
  input  wire logic       shared_error_line,
  input  wire logic       configuration_complete
);
  logic [7:0] idle_lanes;
  logic [7:0] err_cnt_ff;
  logic [7:0] trig_cnt_ff;

  // Lanes that must stay low in each mode
  always_comb begin
    case (lane_mode)
      MODE_PS1: idle_lanes = 8'hFE;
      MODE_PS2: idle_lanes = 8'hFC;
      MODE_PS4: idle_lanes = 8'hF0;
      default:  idle_lanes = 8'h00;
    endcase
  end

  // Length of low pulses on the error and reconfig lines
  always_ff @(posedge clock) begin
    if (rst) begin
      err_cnt_ff  <= 8'h00;
      trig_cnt_ff <= 8'h00;
    end else begin
      err_cnt_ff  <= src_err_oe ? err_cnt_ff + 8'h01 : 8'h00;
      trig_cnt_ff <= trig_oe ? trig_cnt_ff + 8'h01 : 8'h00;
    end
  end

  default clocking dflt @(posedge clock); endclocking
  default disable iff (rst);

  // ==========
  // Properties
  chk_idle_lanes_low: assert property (shift_clock |-> (data & idle_lanes) == 8'h00)
    else $error("Idle lane high while shifting");
  chk_rise_stable: assert property ($rose(shift_clock) |-> $stable(data))
    else $error("Data moved at a rising shift clock");
  chk_high_short: assert property ($rose(shift_clock) |=> ##1 !shift_clock)
    else $error("Shift clock high phase too long");
  chk_low_phase: assert property ($fell(shift_clock) |-> !shift_clock[*3])
    else $error("Shift clock low phase too short");
  chk_err_stops: assert property (!shared_error_line[*5] |-> !shift_clock && data == 8'h00)
    else $error("Shifting continued during an error");
  chk_done_lines: assert property ((configuration_complete && shared_error_line)[*8] |->
    !shift_clock && data == 8'hFF)
    else $error("End state lines wrong");
  chk_err_pulse: assert property ($fell(src_err_oe) |-> err_cnt_ff == 8'(ERR_PULSE_CYC))
    else $error("Error pulse length wrong");
  chk_trig_pulse: assert property ($fell(trig_oe) |-> trig_cnt_ff == 8'(TRIG_PULSE_CYC))
    else $error("Reconfig pulse length wrong");
  chk_pullup_reset: assert property (disable iff (1'b0) rst |=> err_pullup_en && done_pullup_en)
    else $error("Pull-ups off after reset");
  chk_pullup_pair: assert property (!$past(rst, 2) |->
    $stable(err_pullup_en) && err_pullup_en == done_pullup_en)
    else $error("Pull-up enables moved or disagree");
endmodule
`default_nettype wire

/* File: verif/config_data_output_lanes_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Both ends joined; bench feeds images and models the lane slices
module config_data_output_lanes_tb
  import cfg_lanes_pkg::*;
;
  localparam logic [15:0] SC = 16'h0010;
  logic clock = 1'b0;
  logic rst, in_valid, in_ready, in_last, pullup_disable, fault_in, reconfig_req;
  logic busy, cfg_done, error_active, restart_pulse;
  logic chip_select_in_n, crc_error, sample_valid, chain_enable_out_n, user_mode;
  logic [7:0] in_data;
  logic [7:0] sample_data;
  logic [15:0] seed;
  logic sc_q = 1'b0;
  lane_mode_t lane_mode;
  int n_mismatch = 0;
  int total_checks = 0;
  int rises = 0;
  int full_seen = 0;
  int lanes = 1;
  logic [7:0] exp_q[$];
  // Mode table; smallest mode covering a chain count
  lane_mode_t modes[5] = '{MODE_PS1, MODE_PS2, MODE_PS4, MODE_PS8, MODE_BYTE};
  int lanes_tab[5] = '{1, 2, 4, 8, 8};

  cfg_link_if lnk();
  config_source config_source_inst (.clock, .rst, .in_valid, .in_ready, .in_data, .in_last, .lane_mode,
    .pullup_disable, .fault_in, .reconfig_req, .busy, .cfg_done, .error_active, .restart_pulse, .link(lnk));
  config_sink #(.SAMPLE_COUNT(SC)) config_sink_inst (.clock, .rst, .lane_mode, .chip_select_in_n, .crc_error,
    .sample_data, .sample_valid, .chain_enable_out_n, .user_mode, .link(lnk));
  config_data_output_lanes_monitor mon_inst (.clock(clock), .rst(rst), .lane_mode(lane_mode),
    .shift_clock(lnk.shift_clock), .data(lnk.data), .src_err_oe(lnk.src_err_oe), .trig_oe(lnk.trig_oe),
    .err_pullup_en(lnk.err_pullup_en), .done_pullup_en(lnk.done_pullup_en),
    .shared_error_line(lnk.shared_error_line), .configuration_complete(lnk.configuration_complete));

  always #12.5 clock = ~clock;

  // ==========
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Slices of one byte, lane i of slice k gets bit k*n+i
  function automatic void add_exp(input logic [7:0] b);
    logic [7:0] v;
    for (int k = 0; k < 8 / lanes; k++) begin
      v = 8'h00;
      for (int i = 0; i < lanes; i++) v[i] = b[k * lanes + i];
      exp_q.push_back(v);
    end
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset(input lane_mode_t m, input int ln, input logic pud);
    rst = 1'b1;
    lane_mode = m;
    pullup_disable = pud;
    lanes = ln;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    exp_q.delete();
    rises = 0;
    repeat (3) @(negedge clock);
    check("pullup", {15'h0000, lnk.err_pullup_en}, {15'h0000, ~pud});
  endtask

  // Random bytes back to back, one long stall to force a pause
  task automatic feed(input int nb, input bit last);
    for (int j = 0; j < nb; j++) begin
      seed = lfsr(seed);
      add_exp(seed[7:0]);
      in_valid = 1'b1;
      in_data = seed[7:0];
      in_last = last && j == nb - 1;
      while (in_ready !== 1'b1) begin
        full_seen++;
        @(negedge clock);
      end
      @(negedge clock);
      if (j == 1) begin
        in_valid = 1'b0;
        repeat (30) @(negedge clock);
      end
    end
    in_valid = 1'b0;
  endtask

  task automatic finish_run();
    int n;
    n = 0;
    while (cfg_done !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
    check("cfg_done", {15'h0000, cfg_done}, 16'h0001);
    check("user_mode", {15'h0000, user_mode}, 16'h0001);
    check("chain_en_n", {15'h0000, chain_enable_out_n}, 16'h0000);
    check("end_lines", {7'h00, lnk.shift_clock, lnk.data}, 16'h00FF);
    check("busy", {15'h0000, busy}, 16'h0000);
    check("rises", 16'(rises), SC);
    check("left", 16'(exp_q.size()), 16'h0000);
  endtask

  // Sink error, source fault and reconfig request, each mid-image
  task automatic err_run();
    int n;
    do_reset(MODE_PS4, 4, 1'b0);
    for (int k = 0; k < 3; k++) begin
      feed(3, 1'b0);
      if (k == 0) crc_error = 1'b1;
      else if (k == 1) fault_in = 1'b1;
      else reconfig_req = 1'b1;
      @(negedge clock);
      crc_error = 1'b0;
      fault_in = 1'b0;
      reconfig_req = 1'b0;
      n = 0;
      while (error_active !== 1'b1 && n < 300) begin
        @(negedge clock);
        n++;
      end
      repeat (2) @(negedge clock);
      check("err_lines", {6'h00, error_active, lnk.shift_clock, lnk.data}, 16'h0200);
      n = 0;
      while (restart_pulse !== 1'b1 && n < 600) begin
        @(negedge clock);
        n++;
      end
      check("restart", {15'h0000, restart_pulse}, 16'h0001);
      exp_q.delete();
      rises = 0;
    end
    feed(8, 1'b1);
    finish_run();
  endtask

  // ==========
  // Observers: captured samples and shift clock rises
  always @(negedge clock) begin
    if (!rst && sample_valid === 1'b1) begin
      check("sample", {8'h00, sample_data}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hFFFF);
    end
    if (lnk.shift_clock === 1'b1 && sc_q !== 1'b1) rises++;
    sc_q = lnk.shift_clock;
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    final_report();
  end

  // Main sequence
  initial begin
    seed = 16'h5CAF;
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
    fault_in = 1'b0;
    reconfig_req = 1'b0;
    chip_select_in_n = 1'b0;
    crc_error = 1'b0;
    for (int r = 0; r < 5; r++) begin
      do_reset(modes[r], lanes_tab[r], 1'b0);
      feed(2 * lanes_tab[r], 1'b1);
      finish_run();
    end
    err_run();
    check("fifo_full", {15'h0000, full_seen > 0}, 16'h0001);
    // Deselected member captures nothing and never finishes
    chip_select_in_n = 1'b1;
    do_reset(MODE_PS8, 8, 1'b0);
    feed(2, 1'b1);
    repeat (40) @(negedge clock);
    check("unselected", {15'h0000, chain_enable_out_n}, 16'h0001);
    check("no_capture", 16'(exp_q.size()), 16'h0002);
    check("no_user", {15'h0000, user_mode}, 16'h0000);
    exp_q.delete();
    chip_select_in_n = 1'b0;
    do_reset(MODE_PS1, 1, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
